/* bench/cfo_config_properties.sv */
// Checker for the channel configuration block.
// Sees only the top module's ports; bound to it below.
module cfo_config_props #(
    parameter int NUM_CH = 8
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [cfo_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire cfo_pkg::cfo_eff_t [NUM_CH-1:0] o_chan,
    input wire logic o_input_a_sel,
    input wire logic o_boost,
    input wire logic o_sleep
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    // Restore request on word 0
    sequence s_restore;
        i_wr && i_addr == cfo_pkg::ADDR_CH0 && i_wdata[31];
    endsequence
    // Write to the global word
    sequence s_glob;
        i_wr && i_addr == cfo_pkg::ADDR_GLOBAL;
    endsequence
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rd_b31;
        i_rd && i_addr == cfo_pkg::ADDR_CH0 |=> !o_rdata[31];
    endproperty
    a_rd_b31: assert property (p_rd_b31) else $error("restore bit read as one");
    property p_unmapped;
        i_rd && (i_addr == 4'h8 || (i_addr >= 4'ha && i_addr <= 4'hd)) |=> o_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_sleep;
        o_sleep |-> !o_input_a_sel && !o_boost && !o_chan[0].active && !o_chan[7].active;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not overriding");
    property p_glob;
        s_glob |-> ##2 o_sleep == $past(i_wdata[26], 2)
            && ($past(i_wdata[27], 2) || !o_chan[5].active);
    endproperty
    a_glob: assert property (p_glob) else $error("global word not applied");
    property p_byp_lat;
        !o_chan[0].dly_used |-> o_chan[0].delay_ps == (o_chan[0].div_used ? 12'h064 : 12'h000);
    endproperty
    a_byp_lat: assert property (p_byp_lat) else $error("undelayed latency wrong");
    property p_dly_lat;
        o_chan[7].dly_used |-> (int'(o_chan[7].delay_ps) - (o_chan[7].div_used ? 500 : 400))
            inside {0, 150, 300, 450, 600, 750, 900, 1050, 1200, 1350, 1500, 1650, 1800, 1950,
            2100, 2250};
    endproperty
    a_dly_lat: assert property (p_dly_lat) else $error("delayed latency wrong");
    property p_ch_div;
        i_wr && i_addr == 4'h3 |-> ##2 o_chan[3].divider == $past(i_wdata[15:8], 2);
    endproperty
    a_ch_div: assert property (p_ch_div) else $error("divider not applied");
    property p_restore;
        s_restore |-> ##2 o_chan[0].divider == 8'h01 && !o_chan[0].active
            && o_chan[0].delay_ps == 12'h000 && !o_input_a_sel && !o_boost;
    endproperty
    a_restore: assert property (p_restore) else $error("restore left settings");
endmodule

bind cfo_config cfo_config_props #(.NUM_CH(NUM_CH)) u_props (.i_mclk, .i_reset_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_chan, .o_input_a_sel, .o_boost, .o_sleep);

/* bench/cfo_far_end.sv */
// Far side: downstream devices that see which outputs run.
// The bench commands the alignment pulse after dividers change.
module cfo_far_end (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire cfo_pkg::cfo_eff_t [7:0] i_chan,
    input wire logic i_align,
    output logic [7:0] o_live,
    output logic o_aligned
);
    timeunit 1ns;
    timeprecision 1ps;
    // Receivers with a running clock
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            o_live[n] = i_chan[n].active;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_aligned <= 1'b0;
        end else if (i_align) begin
            o_aligned <= 1'b1;
        end
    end
endmodule

/* bench/testbench.sv */
// Register-level bench for the channel configuration block.
// Assumes the design package and the far-end model are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic align = 1'b0;
    logic [31:0] rdata;
    cfo_pkg::cfo_eff_t [7:0] chan;
    logic a_sel, boost, sleep, aligned;
    logic [7:0] live;
    logic [31:0] word;
    int lat;
    int miscompares = 0;
    int n_compared = 0;
    always #2 clk = ~clk;
    cfo_config u_dut (.i_mclk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_chan(chan), .o_input_a_sel(a_sel),
        .o_boost(boost), .o_sleep(sleep));
    cfo_far_end u_far (.i_mclk(clk), .i_reset_n(rst_n), .i_chan(chan), .i_align(align),
        .o_live(live),
        .o_aligned(aligned));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Channel word with a distinct setting per channel
    function automatic logic [31:0] cw(input int n);
        cw = {13'h0, n[1:0], 1'b1, 8'h20 * n[7:0] + 8'h01, 4'((n << 1) + 1), 4'h0};
    endfunction
    // Power-on view of the channel, boost and global words and of unmapped words 8 and b
    task automatic defaults;
        for (int n = 0; n < 8; n++) begin
            rd_reg(n[3:0], 32'h0000_0100);
        end
        rd_reg(4'h9, 32'h0000_0000);
        rd_reg(4'he, 32'h0800_0000);
        rd_reg(4'h8, 32'h0000_0000);
        rd_reg(4'hb, 32'h0000_0000);
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        defaults;
        for (int n = 0; n < 8; n++) begin
            wr_reg(n[3:0], cw(n));
            rd_reg(n[3:0], cw(n));
        end
        settle;
        for (int n = 0; n < 8; n++) begin
            lat = (n % 4 == 0) ? 0 : (n % 4 == 1) ? 100 : (n % 4 == 2) ? 400 : 500;
            lat += n[1] ? ((n << 1) + 1) * 150 : 0;
            word = cw(n);
            chk({9'h0, chan[n]}, {9'h0, 1'b1, n[0], n[1], word[15:8], lat[11:0]});
        end
        chk({24'h0, live}, 32'h0000_00ff);
        rd_reg(4'hf, 32'h0000_00ff);
        align <= 1'b1;
        @(posedge clk);
        align <= 1'b0;
        wr_reg(4'he, 32'h2000_0000);
        settle;
        chk({24'h0, live}, 32'h0000_0000);
        chk({31'h0, a_sel}, 32'h0000_0001);
        chk({31'h0, aligned}, 32'h0000_0001);
        wr_reg(4'h9, 32'h0001_0000);
        wr_reg(4'he, 32'h2c00_0000);
        settle;
        chk({24'h0, live}, 32'h0000_0000);
        chk({29'h0, a_sel, boost, sleep}, 32'h0000_0001);
        wr_reg(4'he, 32'h0800_0000);
        settle;
        chk({29'h0, a_sel, boost, sleep}, 32'h0000_0002);
        wr_reg(4'h8, 32'hffff_ffff);
        wr_reg(4'h0, 32'h8007_ffff);
        settle;
        chk({24'h0, live}, 32'h0000_0000);
        defaults;
        wr_reg(4'h0, 32'h0003_0520);
        rd_reg(4'h0, 32'h0003_0520);
        wrap_up;
    end
endmodule

/* core/cfo_config.sv */
// Configuration registers and effective per-channel controls for an
// eight-channel clock fan-out. Assumes synchronous inputs on i_mclk.
// Function
// RL1: Eight channel words, word n drives channel n
// RL2: Identical channel fields; restore only in word 0
// RL3: Bit 31 of word 0 restores defaults
// RL4: Restore write ignores all other fields
// RL5: Host writes restore bit zero if unused
// RL6: Bits 18:17 choose the output path
// RL7: Path latency added 100, 400, 500 ps
// RL8: Divider bits 15:8 divide by twice value
// RL9: Divider active only in divided modes
// RL10: Host pulses alignment pin after dividers
// RL11: Global bit 29 picks input a or b
// RL12: Global bit 27 all-outputs enable, reset one
// RL13: Global bit 26 sleep control, reset zero
// RL14: Restore bit reads zero after reset
// RL15: Delay setting times 150 ps in delay modes
// RL16: All-outputs enable low disables every output
// RL17: Sleep overrides all other bits and pins
// RL18: Bit 16 enables channel output, reset zero
// RL19: Host writes unassigned bits as map shows
// RL20: Delay setting at bits 7:4, reset zero
module cfo_config #(
    parameter int NUM_CH = 8
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [cfo_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Effective controls
    output cfo_pkg::cfo_eff_t [NUM_CH-1:0] o_chan,
    output logic o_input_a_sel,
    output logic o_boost,
    output logic o_sleep
);

    // Stored settings, one entry per channel
    cfo_pkg::cfo_chan_t chan_q [NUM_CH];
    // Effective controls, one flop set per channel
    cfo_pkg::cfo_eff_t eff_q [NUM_CH];
    logic input_choice_q;
    logic all_outputs_enable_q;
    logic device_sleep_q;
    logic boost_q;
    // Restore request: write to word 0 with bit 31 set
    logic restore;
    // Write to global word
    logic gwr;
    // Write to boost word
    logic bwr;

    // RL3: restore strobe detect
    assign restore = i_wr && (i_addr == cfo_pkg::ADDR_CH0) && i_wdata[cfo_pkg::RESTORE_BIT];
    assign gwr = i_wr && (i_addr == cfo_pkg::ADDR_GLOBAL);
    assign bwr = i_wr && (i_addr == cfo_pkg::ADDR_BOOST);

    // RL1: one word per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // Channel word store
            always_ff @(posedge i_mclk) begin
                // RL3: reset and restore share defaults
                if (!i_reset_n || restore) begin
                    // RL6: bypass default
                    chan_q[g].output_path_select <= cfo_pkg::PATH_RST;
                    // RL18: output off
                    chan_q[g].channel_output_enable <= cfo_pkg::CH_EN_RST;
                    // RL8: divide by two
                    chan_q[g].output_divider_value <= cfo_pkg::DIV_RST;
                    // RL20: no delay
                    chan_q[g].output_delay_setting <= cfo_pkg::DLY_RST;
                end else if (i_wr && (i_addr == cfo_pkg::ADDR_W'(g))) begin
                    // RL2: same field layout for every channel
                    chan_q[g].output_path_select <=
                        i_wdata[cfo_pkg::PATH_HI:cfo_pkg::PATH_LO];
                    chan_q[g].channel_output_enable <= i_wdata[cfo_pkg::CH_EN_BIT];
                    chan_q[g].output_divider_value <= i_wdata[cfo_pkg::DIV_HI:cfo_pkg::DIV_LO];
                    chan_q[g].output_delay_setting <= i_wdata[cfo_pkg::DLY_HI:cfo_pkg::DLY_LO];
                end
            end

            // Effective channel controls
            always_ff @(posedge i_mclk) begin
                if (!i_reset_n) begin
                    eff_q[g] <= '0;
                end else begin
                    // RL16: global enable gate; RL17: sleep wins
                    eff_q[g].active <= chan_q[g].channel_output_enable
                        && all_outputs_enable_q && !device_sleep_q;
                    // RL9: divider only in divided modes
                    eff_q[g].div_used <= chan_q[g].output_path_select[0];
                    // RL15: delay only in delay modes
                    eff_q[g].dly_used <= chan_q[g].output_path_select[1];
                    eff_q[g].divider <= chan_q[g].output_divider_value;
                    // RL7: fixed latency plus programmed delay
                    eff_q[g].delay_ps <= path_delay(chan_q[g]);
                end
            end
        end
    endgenerate

    // Pack the per-channel flops onto the output, one driver only
    always_comb begin
        for (int k = 0; k < NUM_CH; k++) begin
            o_chan[k] = eff_q[k];
        end
    end

    // Total added delay in ps for one channel
    function automatic logic [11:0] path_delay(input cfo_pkg::cfo_chan_t c);
        logic [11:0] fixed_ps;
        logic [11:0] prog_ps;
        fixed_ps = 12'h000;
        prog_ps = 12'h000;
        case (cfo_pkg::cfo_path_t'(c.output_path_select))
            // No added latency
            cfo_pkg::CFO_BYPASS: fixed_ps = 12'h000;
            // Divider stage only
            cfo_pkg::CFO_DIVIDED: fixed_ps = 12'(cfo_pkg::LAT_DIV_PS);
            // Delay stage only
            cfo_pkg::CFO_DELAYED: fixed_ps = 12'(cfo_pkg::LAT_DLY_PS);
            // Both stages
            cfo_pkg::CFO_DIV_DLY: fixed_ps = 12'(cfo_pkg::LAT_BOTH_PS);
            default: fixed_ps = 12'h000;
        endcase
        // RL15: programmed steps count in delay modes only
        if (c.output_path_select[1]) begin
            prog_ps = 12'(c.output_delay_setting * cfo_pkg::DLY_STEP_PS);
        end
        path_delay = 12'(fixed_ps + prog_ps);
    endfunction

    // Global word store
    always_ff @(posedge i_mclk) begin
        // RL3: restore returns global defaults too
        if (!i_reset_n || restore) begin
            // RL11: input b by default
            input_choice_q <= cfo_pkg::INPUT_CHOICE_RST;
            // RL12: outputs under channel control
            all_outputs_enable_q <= cfo_pkg::ALL_EN_RST;
            // RL13: device awake
            device_sleep_q <= cfo_pkg::SLEEP_RST;
        end else if (gwr) begin
            input_choice_q <= i_wdata[cfo_pkg::INPUT_CHOICE_BIT];
            all_outputs_enable_q <= i_wdata[cfo_pkg::ALL_EN_BIT];
            device_sleep_q <= i_wdata[cfo_pkg::SLEEP_BIT];
        end
    end

    // Boost word store
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || restore) begin
            boost_q <= cfo_pkg::BOOST_RST;
        end else if (bwr) begin
            boost_q <= i_wdata[cfo_pkg::BOOST_BIT];
        end
    end

    // Global outputs
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_input_a_sel <= 1'b0;
            o_boost <= 1'b0;
            o_sleep <= 1'b0;
        end else begin
            // RL11: one selects input a
            o_input_a_sel <= input_choice_q && !device_sleep_q;
            o_boost <= boost_q && !device_sleep_q;
            // RL17: sleep flag out
            o_sleep <= device_sleep_q;
        end
    end

    // Status word: live channel activity and sleep
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        for (int k = 0; k < NUM_CH; k++) begin
            status_word[k] = eff_q[k].active;
        end
        status_word[cfo_pkg::SLEEP_BIT] = device_sleep_q;
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= '0;
            if (i_addr < cfo_pkg::ADDR_W'(NUM_CH)) begin
                // RL14: restore bit always reads zero
                o_rdata[cfo_pkg::PATH_HI:cfo_pkg::PATH_LO] <=
                    chan_q[i_addr[2:0]].output_path_select;
                o_rdata[cfo_pkg::CH_EN_BIT] <= chan_q[i_addr[2:0]].channel_output_enable;
                o_rdata[cfo_pkg::DIV_HI:cfo_pkg::DIV_LO] <=
                    chan_q[i_addr[2:0]].output_divider_value;
                o_rdata[cfo_pkg::DLY_HI:cfo_pkg::DLY_LO] <=
                    chan_q[i_addr[2:0]].output_delay_setting;
            end else if (i_addr == cfo_pkg::ADDR_GLOBAL) begin
                o_rdata[cfo_pkg::INPUT_CHOICE_BIT] <= input_choice_q;
                o_rdata[cfo_pkg::ALL_EN_BIT] <= all_outputs_enable_q;
                o_rdata[cfo_pkg::SLEEP_BIT] <= device_sleep_q;
            end else if (i_addr == cfo_pkg::ADDR_BOOST) begin
                o_rdata[cfo_pkg::BOOST_BIT] <= boost_q;
            end else if (i_addr == cfo_pkg::ADDR_STATUS) begin
                o_rdata <= status_word;
            end
        end else begin
            // Data stand for one cycle only
            o_rdata <= '0;
        end
    end

endmodule

/* inc/cfo_pkg.sv */
// Package for the clock output channel configuration block.
// Assumes a single 250 MHz clock and a plain register port.
package cfo_pkg;
    // Register indices on the plain port
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CH0 = 4'h0;
    localparam logic [3:0] ADDR_BOOST = 4'h9;
    localparam logic [3:0] ADDR_GLOBAL = 4'he;
    localparam logic [3:0] ADDR_STATUS = 4'hf;
    // Channel word field positions
    localparam int RESTORE_BIT = 31;
    localparam int PATH_HI = 18;
    localparam int PATH_LO = 17;
    localparam int CH_EN_BIT = 16;
    localparam int DIV_HI = 15;
    localparam int DIV_LO = 8;
    localparam int DLY_HI = 7;
    localparam int DLY_LO = 4;
    // Global word field positions
    localparam int INPUT_CHOICE_BIT = 29;
    localparam int ALL_EN_BIT = 27;
    localparam int SLEEP_BIT = 26;
    // Boost word field position
    localparam int BOOST_BIT = 16;
    // Reset values
    localparam logic [1:0] PATH_RST = 2'h0;
    localparam logic CH_EN_RST = 1'b0;
    localparam logic [7:0] DIV_RST = 8'h01;
    localparam logic [3:0] DLY_RST = 4'h0;
    localparam logic INPUT_CHOICE_RST = 1'b0;
    localparam logic ALL_EN_RST = 1'b1;
    localparam logic SLEEP_RST = 1'b0;
    localparam logic BOOST_RST = 1'b0;
    // Fixed path latencies in ps
    localparam int LAT_DIV_PS = 100;
    localparam int LAT_DLY_PS = 400;
    localparam int LAT_BOTH_PS = 500;
    localparam int DLY_STEP_PS = 150;
    // Output path modes
    typedef enum logic [1:0] {
        CFO_BYPASS = 2'h0,
        CFO_DIVIDED = 2'h1,
        CFO_DELAYED = 2'h2,
        CFO_DIV_DLY = 2'h3
    } cfo_path_t;
    // One channel's settings
    typedef struct packed {
        logic [1:0] output_path_select;
        logic channel_output_enable;
        logic [7:0] output_divider_value;
        logic [3:0] output_delay_setting;
    } cfo_chan_t;
    // Per channel effective control
    typedef struct packed {
        logic active;
        logic div_used;
        logic dly_used;
        logic [7:0] divider;
        logic [11:0] delay_ps;
    } cfo_eff_t;
endpackage
